// File: include/io_block_pkg.sv
// Constants, encodings and register map of the port transfer sequencer
package io_block_pkg;

  // Instruction bytes
  localparam logic [7:0] OP_EXT_PREFIX  = 8'hED;
  localparam logic [7:0] OP_OUT_IMM     = 8'hD3;
  localparam logic [7:0] OP_IN_DOWN     = 8'hAA;
  localparam logic [7:0] OP_IN_DOWN_RPT = 8'hBA;
  localparam logic [7:0] OP_IN_UP_RPT   = 8'hB2;
  localparam logic [7:0] OP_OUT_UP      = 8'hA3;
  localparam logic [1:0] OP_OUT_REG_HI  = 2'h1;
  localparam logic [2:0] OP_OUT_REG_LO  = 3'h1;

  // Register select field of the register-indexed port write
  localparam logic [2:0] SEL_B   = 3'h0;
  localparam logic [2:0] SEL_C   = 3'h1;
  localparam logic [2:0] SEL_D   = 3'h2;
  localparam logic [2:0] SEL_E   = 3'h3;
  localparam logic [2:0] SEL_H   = 3'h4;
  localparam logic [2:0] SEL_L   = 3'h5;
  localparam logic [2:0] SEL_BAD = 3'h6;
  localparam logic [2:0] SEL_A   = 3'h7;

  // Flag bit positions
  localparam int FLAG_Z = 6;
  localparam int FLAG_N = 1;

  // Machine cycle lengths in T states; one T state is one clk period
  localparam int         T_W        = 3;
  localparam int         TSTATE_NS  = 10;
  localparam int         CLK_NS     = 10;
  localparam int         T_CLKS     = (TSTATE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] T_FETCH    = 3'h4;
  localparam logic [2:0] T_OPND_IMM = 3'h3;
  localparam logic [2:0] T_OPND_REG = 3'h4;
  localparam logic [2:0] T_OPND_BLK = 3'h5;
  localparam logic [2:0] T_XFER_A   = 3'h3;
  localparam logic [2:0] T_XFER_B   = 3'h4;
  localparam logic [2:0] T_RPT      = 3'h5;
  localparam logic [2:0] RFSH_T0    = 3'h1;
  localparam logic [2:0] RFSH_T1    = 3'h3;
  localparam logic [15:0] PC_STEP   = 16'h0002;

  // Register map, byte addresses
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_OPCODE = 8'h04;
  localparam logic [7:0] OFS_BC     = 8'h08;
  localparam logic [7:0] OFS_DE     = 8'h0C;
  localparam logic [7:0] OFS_HL     = 8'h10;
  localparam logic [7:0] OFS_AF     = 8'h14;
  localparam logic [7:0] OFS_PC     = 8'h18;
  localparam logic [7:0] OFS_TCOUNT = 8'h1C;
  localparam int         CTRL_START   = 0;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_ILLEGAL = 1;
  localparam int         STAT_INTR    = 2;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [2:0] {
    INS_BAD         = 3'b000,
    INS_OUT_IMM     = 3'b001,
    INS_OUT_REG     = 3'b010,
    INS_IN_DOWN     = 3'b011,
    INS_IN_DOWN_RPT = 3'b100,
    INS_IN_UP_RPT   = 3'b101,
    INS_OUT_UP      = 3'b110
  } ins_e;

  typedef enum logic [2:0] {
    MC_IDLE  = 3'b000,
    MC_FETCH = 3'b001,
    MC_OPND  = 3'b010,
    MC_IORD  = 3'b011,
    MC_IOWR  = 3'b100,
    MC_MRD   = 3'b101,
    MC_MWR   = 3'b110,
    MC_RPT   = 3'b111
  } mcycle_e;

endpackage

// File: rtl/tstate_timer.sv
// T-state counter of one machine cycle, stretched by wait states
`timescale 1ns/1ps
module tstate_timer #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic [W-1:0] len,
  input  wire logic         stall,
  output logic [W-1:0]      t_idx,
  output logic              last
);

  if (W < 3) $error("tstate_timer: W must hold a five T-state cycle");

  logic [W-1:0] cnt_reg;

  // Last T state of the cycle; it repeats while stalled
  assign last  = run && (cnt_reg == len - W'(1));
  assign t_idx = cnt_reg;

  // Restart at T1 whenever idle or a cycle completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!run) begin
      cnt_reg <= '0;
    end else if (last) begin
      if (!stall) begin
        cnt_reg <= '0;
      end
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

endmodule

// File: rtl/pair_buffer.sv
// Two-entry valid/ready buffer in the byte path between the two bus cycles
`timescale 1ns/1ps
module pair_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  if (DEPTH != 2) $error("pair_buffer: only two entries are supported");

  logic [W-1:0] slot_reg [DEPTH];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   fill_reg;
  logic         push;
  logic         pop;

  // Full and empty come straight from the fill count
  assign in_ready  = (fill_reg != 2'h2);
  assign out_valid = (fill_reg != 2'h0);
  assign out_data  = slot_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Slot storage
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        slot_reg[g] <= '0;
      end else if (push && (wr_ptr_reg == 1'(g))) begin
        slot_reg[g] <= in_data;
      end
    end
  end

  // Pointers and fill count; push and pop may coincide
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        fill_reg <= fill_reg + 2'h1;
      end else if (pop && !push) begin
        fill_reg <= fill_reg - 2'h1;
      end
    end
  end

endmodule

// File: rtl/io_block_seq.sv
// Sequencer of port write and block port transfer instructions, Wishbone controlled
//
// Contract
// - Up-repeat input stores each byte at pointer, pointer up, count down, stops at zero.
// - Each non-final repeat iteration takes five cycles, T states 4,5,3,4,5.
// - Single-step and final repeat iteration take four cycles, T states 4,5,3,4.
// - Repeat completion sets zero and subtract flags, carry kept, others left.
// - Down single input then decrements count and pointer pair.
// - Down single input: zero flag from count minus one, subtract set, carry kept.
// - Down-repeat input stores each byte, then decrements pointer and count.
// - Repeat with nonzero count rewinds program counter by two and re-executes.
// - Between iterations take pending interrupt and give two refresh pulses in one repeat cycle.
// - Count of zero at start means 256 bytes.
// - Immediate port write: port byte low, result register high, writes result register.
// - Immediate port write: T states 4,3,4, flags untouched.
// - Indexed port write: port index low, count high, writes selected register.
// - Indexed select field decode; T states 4,4,4; flags untouched.
// - Up single output reads memory byte, decrements count, outputs with new count high.
// - Up single output finally increments the pointer pair.
`timescale 1ns/1ps
module io_block_seq
  import io_block_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        int_req,
  output logic [15:0]      io_addr,
  output logic [7:0]       io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_ack,
  output logic             io_mreq,
  output logic             io_iorq,
  output logic             io_rd,
  output logic             io_wr,
  output logic             io_rfsh
);

  logic [7:0]     b_reg, c_reg, d_reg, e_reg, h_reg, l_reg, a_reg, f_reg;
  logic [15:0]    pc_reg;
  logic [15:0]    op_reg;
  logic [15:0]    tcount_reg;
  logic           busy_reg;
  logic           illegal_reg;
  logic           intr_reg;
  ins_e           ins_reg;
  logic [2:0]     step_reg;
  logic           ack_reg;
  logic [31:0]    rdata_reg;
  logic [15:0]    addr_reg;
  logic [7:0]     wdata_reg;
  mcycle_e        kind;
  logic [T_W-1:0] len;
  logic [T_W-1:0] t_idx;
  logic           t_last;
  logic           stall;
  logic           step_done;
  logic           bus_cycle;
  logic           is_rd;
  logic           wr_from_buf;
  logic           repeating;
  logic           wb_req;
  logic           wr_commit;
  logic           sw_write;
  logic           start_req;
  ins_e           dec_ins;
  logic [31:0]    rd_mux;
  logic           buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [7:0]     buf_out_data;
  logic [15:0]    hl_val;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Instruction class from the two instruction bytes
  function automatic ins_e decode_ins(input logic [15:0] op);
    ins_e r;
    r = INS_BAD;
    if (op[7:0] == OP_OUT_IMM) begin
      r = INS_OUT_IMM;
    end else if (op[7:0] == OP_EXT_PREFIX) begin
      if (op[15:14] == OP_OUT_REG_HI && op[10:8] == OP_OUT_REG_LO && op[13:11] != SEL_BAD) begin
        r = INS_OUT_REG;
      end else if (op[15:8] == OP_IN_DOWN) begin
        r = INS_IN_DOWN;
      end else if (op[15:8] == OP_IN_DOWN_RPT) begin
        r = INS_IN_DOWN_RPT;
      end else if (op[15:8] == OP_IN_UP_RPT) begin
        r = INS_IN_UP_RPT;
      end else if (op[15:8] == OP_OUT_UP) begin
        r = INS_OUT_UP;
      end
    end
    return r;
  endfunction

  // Machine cycle kind of each step
  function automatic mcycle_e step_kind(input ins_e ins, input logic [2:0] step);
    mcycle_e k;
    k = MC_IDLE;
    unique case (step)
      3'h0: k = MC_FETCH;
      3'h1: k = MC_OPND;
      3'h2: begin
        if (ins == INS_OUT_IMM || ins == INS_OUT_REG) begin
          k = MC_IOWR;
        end else if (ins == INS_OUT_UP) begin
          k = MC_MRD;
        end else begin
          k = MC_IORD;
        end
      end
      3'h3: k = (ins == INS_OUT_UP) ? MC_IOWR : MC_MWR;
      3'h4: k = MC_RPT;
      default: k = MC_IDLE;
    endcase
    return k;
  endfunction

  // T states of each machine cycle
  function automatic logic [2:0] step_len(input ins_e ins, input mcycle_e k);
    logic [2:0] n;
    n = T_FETCH;
    unique case (k)
      MC_IDLE, MC_FETCH: n = T_FETCH;
      MC_OPND: begin
        if (ins == INS_OUT_IMM) begin
          n = T_OPND_IMM;
        end else if (ins == INS_OUT_REG) begin
          n = T_OPND_REG;
        end else begin
          n = T_OPND_BLK;
        end
      end
      MC_IORD, MC_MRD:  n = T_XFER_A;
      MC_MWR, MC_IOWR:  n = T_XFER_B;
      MC_RPT:           n = T_RPT;
    endcase
    return n;
  endfunction

  // Byte named by the select field
  function automatic logic [7:0] sel_byte(input logic [2:0] s, input logic [7:0] b, input logic [7:0] c,
                                          input logic [7:0] d, input logic [7:0] e, input logic [7:0] h,
                                          input logic [7:0] l, input logic [7:0] a);
    logic [7:0] v;
    v = a;
    unique case (s)
      SEL_B:   v = b;
      SEL_C:   v = c;
      SEL_D:   v = d;
      SEL_E:   v = e;
      SEL_H:   v = h;
      SEL_L:   v = l;
      default: v = a;
    endcase
    return v;
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [15:0] v;
    v = old;
    if (sel[0]) v[7:0] = dat[7:0];
    if (sel[1]) v[15:8] = dat[15:8];
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencing

  assign kind      = busy_reg ? step_kind(ins_reg, step_reg) : MC_IDLE;
  assign len       = T_W'(step_len(ins_reg, kind));
  assign bus_cycle = (kind == MC_IORD) || (kind == MC_IOWR) || (kind == MC_MRD) || (kind == MC_MWR);
  assign is_rd     = (kind == MC_IORD) || (kind == MC_MRD);
  assign wr_from_buf = (kind == MC_MWR) || (kind == MC_IOWR && ins_reg == INS_OUT_UP);
  assign repeating = (ins_reg == INS_IN_DOWN_RPT) || (ins_reg == INS_IN_UP_RPT);
  assign hl_val    = {h_reg, l_reg};

  // Wait states: hold the last T state until the far side answers and the buffer can move
  assign stall = t_last && bus_cycle &&
                 (!io_ack || (is_rd && !buf_in_ready) || (wr_from_buf && !buf_out_valid));
  assign step_done = t_last && !stall;

  tstate_timer #(
    .W (T_W)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .run   (busy_reg),
    .len   (len),
    .stall (stall),
    .t_idx (t_idx),
    .last  (t_last)
  );

  // Bytes read from a port or memory wait here for the following write cycle
  assign buf_in_valid  = step_done && is_rd;
  assign buf_out_ready = step_done && wr_from_buf;

  pair_buffer #(
    .W     (8),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (io_rdata),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // Step walker; an interrupt is only looked at between iterations
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      ins_reg  <= INS_BAD;
      step_reg <= 3'h0;
    end else if (!busy_reg) begin
      if (start_req && dec_ins != INS_BAD) begin
        busy_reg <= 1'b1;
        ins_reg  <= dec_ins;
        step_reg <= 3'h0;
      end
    end else if (step_done) begin
      unique case (kind)
        MC_IOWR: busy_reg <= 1'b0;
        MC_MWR: begin
          if (repeating && b_reg != 8'h01) begin
            step_reg <= step_reg + 3'h1;
          end else begin
            busy_reg <= 1'b0;
          end
        end
        MC_RPT: begin
          if (int_req) begin
            busy_reg <= 1'b0;
          end else begin
            step_reg <= 3'h0;
          end
        end
        default: step_reg <= step_reg + 3'h1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor bus

  // Address and data load at the end of T1 and stand from T2 on, the same T state the strobes start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg  <= RST_WORD;
      wdata_reg <= RST_BYTE;
    end else if (bus_cycle && t_idx == '0) begin
      unique case (kind)
        MC_MRD, MC_MWR: addr_reg <= hl_val;
        MC_IOWR: begin
          if (ins_reg == INS_OUT_IMM) begin
            addr_reg <= {a_reg, op_reg[15:8]};
          end else begin
            addr_reg <= {b_reg, c_reg};
          end
        end
        default: addr_reg <= {b_reg, c_reg};
      endcase
      if (ins_reg == INS_OUT_IMM) begin
        wdata_reg <= a_reg;
      end else if (ins_reg == INS_OUT_REG) begin
        wdata_reg <= sel_byte(op_reg[13:11], b_reg, c_reg, d_reg, e_reg, h_reg, l_reg, a_reg);
      end else begin
        wdata_reg <= buf_out_data;
      end
    end
  end

  assign io_addr  = addr_reg;
  assign io_wdata = wdata_reg;
  assign io_iorq  = bus_cycle && t_idx != '0 && (kind == MC_IORD || kind == MC_IOWR);
  assign io_mreq  = bus_cycle && t_idx != '0 && (kind == MC_MRD || kind == MC_MWR);
  assign io_rd    = bus_cycle && t_idx != '0 && is_rd;
  assign io_wr    = bus_cycle && t_idx != '0 && !is_rd;
  // Two refresh pulses in the cycle that separates iterations
  assign io_rfsh  = (kind == MC_RPT) && (t_idx == RFSH_T0 || t_idx == RFSH_T1);

  ////////////////////////////////////////////////////////////////////////////
  // Counter, pointer, flags and program counter

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_reg  <= RST_BYTE;
      h_reg  <= RST_BYTE;
      l_reg  <= RST_BYTE;
      f_reg  <= RST_BYTE;
      pc_reg <= RST_WORD;
    end else if (sw_write) begin
      if (wb_adr_i == OFS_BC && wb_sel_i[1]) b_reg <= wb_dat_i[15:8];
      if (wb_adr_i == OFS_HL) {h_reg, l_reg} <= merge16(hl_val, wb_dat_i, wb_sel_i);
      if (wb_adr_i == OFS_AF && wb_sel_i[0]) f_reg <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_PC) pc_reg <= merge16(pc_reg, wb_dat_i, wb_sel_i);
    end else if (step_done) begin
      unique case (kind)
        MC_OPND: pc_reg <= pc_reg + PC_STEP;
        MC_MRD:  b_reg <= b_reg - 8'h01;
        MC_MWR: begin
          b_reg <= b_reg - 8'h01;
          if (ins_reg == INS_IN_UP_RPT) begin
            {h_reg, l_reg} <= hl_val + 16'h0001;
          end else begin
            {h_reg, l_reg} <= hl_val - 16'h0001;
          end
          f_reg[FLAG_Z] <= (b_reg == 8'h01);
          f_reg[FLAG_N] <= 1'b1;
        end
        MC_IOWR: begin
          if (ins_reg == INS_OUT_UP) begin
            {h_reg, l_reg} <= hl_val + 16'h0001;
            f_reg[FLAG_Z]  <= (b_reg == 8'h00);
            f_reg[FLAG_N]  <= 1'b1;
          end
        end
        MC_RPT:  pc_reg <= pc_reg - PC_STEP;
        default: pc_reg <= pc_reg;
      endcase
    end
  end

  // Registers that only software changes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_reg  <= RST_BYTE;
      d_reg  <= RST_BYTE;
      e_reg  <= RST_BYTE;
      a_reg  <= RST_BYTE;
      op_reg <= RST_WORD;
    end else if (sw_write) begin
      if (wb_adr_i == OFS_BC && wb_sel_i[0]) c_reg <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_DE) {d_reg, e_reg} <= merge16({d_reg, e_reg}, wb_dat_i, wb_sel_i);
      if (wb_adr_i == OFS_AF && wb_sel_i[1]) a_reg <= wb_dat_i[15:8];
      if (wb_adr_i == OFS_OPCODE) op_reg <= merge16(op_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Status: sticky until the next accepted start, which cannot coincide with a set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      illegal_reg <= 1'b0;
      intr_reg    <= 1'b0;
      tcount_reg  <= RST_WORD;
    end else if (!busy_reg) begin
      if (start_req) begin
        illegal_reg <= (dec_ins == INS_BAD);
        intr_reg    <= 1'b0;
        tcount_reg  <= RST_WORD;
      end
    end else begin
      tcount_reg <= tcount_reg + 16'h0001;
      if (step_done && kind == MC_RPT && int_req) begin
        intr_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, writes refused while an instruction runs

  assign wb_req    = wb_cyc_i && wb_stb_i;
  assign wr_commit = wb_req && wb_we_i && ack_reg;
  assign sw_write  = wr_commit && !busy_reg && wb_adr_i != OFS_CTRL;
  assign start_req = wr_commit && wb_adr_i == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START];
  assign dec_ins   = decode_ins(op_reg);
  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = rdata_reg;

  // Read multiplexer; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CTRL: begin
        rd_mux[STAT_BUSY]    = busy_reg;
        rd_mux[STAT_ILLEGAL] = illegal_reg;
        rd_mux[STAT_INTR]    = intr_reg;
      end
      OFS_OPCODE: rd_mux[15:0] = op_reg;
      OFS_BC:     rd_mux[15:0] = {b_reg, c_reg};
      OFS_DE:     rd_mux[15:0] = {d_reg, e_reg};
      OFS_HL:     rd_mux[15:0] = hl_val;
      OFS_AF:     rd_mux[15:0] = {a_reg, f_reg};
      OFS_PC:     rd_mux[15:0] = pc_reg;
      OFS_TCOUNT: rd_mux[15:0] = tcount_reg;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Ack follows the request by one cycle and drops right after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req && !ack_reg;
      if (wb_req && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

endmodule

// File: bench/io_block_seq_chk.sv
// Bus timing checker of the port transfer sequencer
`timescale 1ns/1ps
module io_block_seq_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [15:0] io_addr,
  input wire logic        io_ack,
  input wire logic        io_mreq,
  input wire logic        io_iorq,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic        io_rfsh
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus answer timing
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  // Refresh pair sits in the repeat cycle right after the memory write
  a_rfsh_pair: assert property ($rose(io_rfsh) && !$past(io_rfsh, 2) |=> !io_rfsh ##1 io_rfsh ##1 !io_rfsh)
    else $error("refresh pulses wrong");
  a_rfsh_after_wr: assert property ($rose(io_rfsh) && !$past(io_rfsh, 2) |-> $past(io_mreq && io_wr, 2))
    else $error("refresh not after store");
  // Port read is three states, then the store follows
  a_iord_len: assert property ($rose(io_iorq && io_rd) ##1 io_ack |=> !io_rd)
    else $error("port read length wrong");
  a_store_next: assert property ($fell(io_iorq && io_rd) |=> io_mreq && io_wr)
    else $error("no store after port read");
  a_iowr_len: assert property ($rose(io_iorq && io_wr) |-> io_wr [*3])
    else $error("port write too short");
  // Address may not move while a strobe stands
  a_addr_hold: assert property ((io_iorq || io_mreq) && $past(io_iorq || io_mreq) |-> $stable(io_addr))
    else $error("address moved in strobe");
  a_no_clash: assert property (!(io_rd && io_wr) && !(io_mreq && io_iorq))
    else $error("strobes clash");
  c_rfsh: cover property ($rose(io_rfsh));
  c_iowr: cover property ($rose(io_iorq && io_wr));
  c_wait: cover property (io_rd && !io_ack);
endmodule
bind io_block_seq io_block_seq_chk io_block_seq_chk_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .io_addr(io_addr), .io_ack(io_ack), .io_mreq(io_mreq),
  .io_iorq(io_iorq), .io_rd(io_rd), .io_wr(io_wr), .io_rfsh(io_rfsh));

// File: bench/io_far_model.sv
// Far side model: one port peripheral and a byte memory
`timescale 1ns/1ps
module io_far_model (
  input  wire logic        clk,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_mreq,
  input  wire logic        io_iorq,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic        slow,
  output logic [7:0]       io_rdata,
  output logic             io_ack
);
  logic [7:0]  mem [0:255];
  logic [7:0]  cnt = 8'h00;
  logic [7:0]  last = 8'h00;
  logic        prd = 1'h0;
  logic [15:0] wadr = 16'h0000;
  logic [7:0]  wdat = 8'h00;
  initial begin
    io_ack = 1'h1;
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
  end
  // Idle data lines show the inverse of the last byte, never a stale copy
  assign io_rdata = io_rd ? (io_iorq ? 8'hA0 + cnt : mem[io_addr[7:0]]) : ~last;
  // Port bytes advance once per finished read; slow mode toggles ack for waits
  always @(posedge clk) begin
    prd <= io_iorq && io_rd;
    if (prd && !(io_iorq && io_rd)) cnt <= cnt + 8'h01;
    if (io_rd) last <= io_rdata;
    if (io_mreq && io_wr) mem[io_addr[7:0]] <= io_wdata;
    if (io_iorq && io_wr) wadr <= io_addr;
    if (io_iorq && io_wr) wdat <= io_wdata;
    io_ack <= slow ? ~io_ack : 1'h1;
  end
endmodule

// File: bench/cpu_port_io_block_transfer_test.sv
// Testbench of the port transfer sequencer
`timescale 1ns/1ps
module cpu_port_io_block_transfer_test;
  import io_block_pkg::*;
  logic clk, rst, cyc, stb, we, int_req, slow;
  logic [7:0] adr, io_rdata;
  logic [31:0] dat, wb_dat_o;
  logic wb_ack_o, io_ack, io_mreq, io_iorq, io_rd, io_wr, io_rfsh;
  logic [15:0] io_addr;
  logic [7:0] io_wdata;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] rv [8] = '{8'h10, 8'h07, 8'h5A, 8'h3C, 8'h80, 8'h40, 8'h00, 8'h23};
  io_block_seq io_block_seq_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .int_req(int_req), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
    .io_mreq(io_mreq), .io_iorq(io_iorq), .io_rd(io_rd), .io_wr(io_wr), .io_rfsh(io_rfsh));
  io_far_model io_far_model_i (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_mreq(io_mreq),
    .io_iorq(io_iorq), .io_rd(io_rd), .io_wr(io_wr), .slow(slow), .io_rdata(io_rdata), .io_ack(io_ack));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; the wait for ack is bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (wb_ack_o !== 1'h1) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic get(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    xfer(1'h0, a, 32'h0, q);
    chk($sformatf("reg %h", a), {16'h0000, q[15:0]}, {16'h0000, e});
  endtask
  task automatic setr(input logic [15:0] bc, input logic [15:0] hl);
    logic [31:0] q;
    xfer(1'h1, OFS_BC, {16'h0000, bc}, q);
    xfer(1'h1, OFS_HL, {16'h0000, hl}, q);
    xfer(1'h1, OFS_PC, 32'h0000_0100, q);
  endtask
  // Start an instruction and poll busy with a bound
  task automatic run(input logic [15:0] op);
    logic [31:0] q;
    int n;
    xfer(1'h1, OFS_OPCODE, {16'h0000, op}, q);
    xfer(1'h1, OFS_CTRL, 32'h0000_0001, q);
    n = 0;
    do begin
      xfer(1'h0, OFS_CTRL, 32'h0, q);
      n++;
    end while (q[STAT_BUSY] !== 1'h0 && n < 3000);
    if (q[STAT_BUSY] !== 1'h0) begin
      miscompares++;
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    rst = 1'h1;
    {cyc, stb, we, int_req, slow} = 5'h00;
    adr = 8'h00;
    dat = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    get(OFS_BC, 16'h0000);
    xfer(1'h1, OFS_AF, 32'h2300, q);
    xfer(1'h1, OFS_DE, 32'h5A3C, q);
    setr(16'h1007, 16'h8040);
    run(16'h01D3);
    chk("port addr", io_far_model_i.wadr, 16'h2301);
    chk("port data", io_far_model_i.wdat, 8'h23);
    get(OFS_TCOUNT, 16'd11);
    get(OFS_AF, 16'h2300);
    for (int s = 0; s < 8; s++) if (s != 6) begin
      run({2'h1, s[2:0], 3'h1, OP_EXT_PREFIX});
      chk("sel data", io_far_model_i.wdat, rv[s]);
      chk("sel addr", io_far_model_i.wadr, 16'h1007);
      get(OFS_TCOUNT, 16'd12);
    end
    run(16'h71ED);
    get(OFS_CTRL, 16'h0002);
    $display("port write tests done");
    setr(16'h1007, 16'h1040);
    run(16'hAAED);
    chk("store", io_far_model_i.mem[8'h40], 8'hA0);
    get(OFS_BC, 16'h0F07);
    get(OFS_HL, 16'h103F);
    get(OFS_AF, 16'h2302);
    get(OFS_TCOUNT, 16'd16);
    setr(16'h0307, 16'h1050);
    run(16'hB2ED);
    for (int i = 0; i < 3; i++) chk("up", io_far_model_i.mem[8'h50 + i], 8'hA1 + i);
    get(OFS_HL, 16'h1053);
    get(OFS_AF, 16'h2342);
    get(OFS_TCOUNT, 16'd58);
    get(OFS_PC, 16'h0102);
    slow <= 1'h1;
    setr(16'h0207, 16'h1060);
    run(16'hBAED);
    slow <= 1'h0;
    chk("down", io_far_model_i.mem[8'h5F], 8'hA5);
    get(OFS_HL, 16'h105E);
    get(OFS_BC, 16'h0007);
    $display("block input tests done");
    setr(16'h1007, 16'h1070);
    run(16'hA3ED);
    chk("out addr", io_far_model_i.wadr, 16'h0F07);
    chk("out data", io_far_model_i.wdat, 8'h2A);
    get(OFS_HL, 16'h1071);
    setr(16'h0007, 16'h1000);
    run(16'hB2ED);
    get(OFS_HL, 16'h1100);
    chk("wrap", io_far_model_i.mem[8'hFF], 8'hA5);
    int_req <= 1'h1;
    setr(16'h0507, 16'h1200);
    run(16'hB2ED);
    int_req <= 1'h0;
    get(OFS_CTRL, 16'h0004);
    get(OFS_BC, 16'h0407);
    get(OFS_PC, 16'h0100);
    xfer(1'h1, 8'h40, 32'h1234, q);
    get(8'h40, 16'h0000);
    $display("output and abort tests done");
    test_done();
  end
endmodule
